// File: design/ars_pkg.sv
// Shared constants for the read-sector command interpreter
package ars_pkg;
    // ------------------------------------------------------------
    // Task-file port addresses
    // ------------------------------------------------------------
    localparam logic [9:0] ADR_FEATURE = 10'h01f1;
    localparam logic [9:0] ADR_COUNT = 10'h01f2;
    localparam logic [9:0] ADR_SECTOR = 10'h01f3;
    localparam logic [9:0] ADR_CYL_LO = 10'h01f4;
    localparam logic [9:0] ADR_CYL_HI = 10'h01f5;
    localparam logic [9:0] ADR_DEV_HEAD = 10'h01f6;
    localparam logic [9:0] ADR_COMMAND = 10'h01f7;
    // ------------------------------------------------------------
    // Field positions and codes
    // ------------------------------------------------------------
    localparam int DH_LBA_BIT = 6;
    localparam int DH_DRV_BIT = 4;
    localparam int ST_BUSY = 7;
    localparam int ST_READY = 6;
    localparam int ST_SEEKED = 4;
    localparam int ST_DRQ = 3;
    localparam int ST_ERR = 0;
    localparam int FLT_UNC = 6;
    localparam int FLT_ABORT = 2;
    localparam logic [7:0] OP_READ = 8'h20;
    localparam logic [7:0] OP_READ_ALT = 8'h21;
    localparam logic [7:0] OP_DIAG = 8'h90;
    localparam logic [7:0] DIAG_PASS = 8'h01;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_COUNT = 8'h01;
    localparam logic [7:0] RST_SECTOR = 8'h01;
    localparam logic [8:0] MAX_COUNT = 9'h100;
    // ------------------------------------------------------------
    // Geometry of the medium
    // ------------------------------------------------------------
    localparam logic [7:0] SECT_PER_TRACK = 8'h3f;
    localparam logic [3:0] HEAD_COUNT = 4'hf;
    localparam logic [27:0] TRACK_SIZE = 28'h000_03b1;
endpackage

// File: design/ars_sync3.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module ars_sync3
    import ars_pkg::*;
#(
    parameter logic INIT = 1'b1
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic din,
    output logic dout
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    always_ff @(posedge clk) begin
        if (srst) begin
            s1_r <= INIT;
            s2_r <= INIT;
            s3_r <= INIT;
            dout <= INIT;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
            // A change only counts once stages two and three agree
            if (s2_r == s3_r) begin
                dout <= s3_r;
            end
        end
    end
endmodule

// File: design/ars_addr_step.sv
// Next-sector address in CHS or LBA form
`timescale 1ns/1ps
module ars_addr_step
    import ars_pkg::*;
(
    input wire logic [27:0] cur,
    input wire logic lba_mode,
    output logic [27:0] nxt
);
    logic [7:0] sn;
    logic [15:0] cyl;
    logic [3:0] head;

    always_comb begin
        sn = cur[7:0];
        cyl = cur[23:8];
        head = cur[27:24];
        if (lba_mode) begin
            nxt = cur + 28'h000_0001;
        end else if (sn < SECT_PER_TRACK) begin
            nxt = {head, cyl, sn + 8'h01};
        end else if (head < HEAD_COUNT) begin
            nxt = {head + 4'h1, cyl, RST_SECTOR};
        end else begin
            nxt = {4'h0, cyl + 16'h0001, RST_SECTOR};
        end
    end
endmodule

// File: design/ars_read_sector_top.sv
// Task-file registers and read-sector command sequencer
`timescale 1ns/1ps
module ars_read_sector_top
    import ars_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic SRST,
    input wire logic [9:0] HOST_ADDR,
    input wire logic [7:0] HOST_WDATA,
    input wire logic HOST_WR_N,
    input wire logic HOST_RD_N,
    output logic [7:0] HOST_RDATA,
    input wire logic SLAVE_STRAP,
    output logic SEEK_REQ,
    output logic [15:0] SEEK_CYL,
    input wire logic SEEK_DONE,
    output logic MEDIA_REQ,
    output logic [27:0] MEDIA_ADDR,
    output logic MEDIA_LBA,
    input wire logic MEDIA_DONE,
    input wire logic MEDIA_ERR,
    output logic DATA_REQ,
    input wire logic XFER_DONE
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    typedef enum logic [2:0] {S_IDLE, S_CHECK, S_SEEK, S_READ, S_XFER} ars_state_e;

    ars_state_e state_r;
    logic wr_n_s;
    logic rd_n_s;
    logic strap_s;
    logic wr_n_d_r;
    logic wr_go;
    logic is_slave_r;
    logic [7:0] count_r;
    logic [7:0] sect_r;
    logic [7:0] cyl_lo_r;
    logic [7:0] cyl_hi_r;
    logic [7:0] dev_head_r;
    logic [7:0] fault_r;
    logic err_r;
    logic [8:0] remain_r;
    logic [15:0] cur_cyl_r;
    logic [27:0] addr;
    logic [27:0] addr_nxt;
    logic lba_mode;
    logic busy;
    logic selected;
    logic cmd_go;
    logic start_read;
    logic step;
    logic [15:0] target_cyl;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    ars_sync3 #(.INIT(1'b1)) u_wr (.clk(SYS_CLK), .srst(SRST), .din(HOST_WR_N), .dout(wr_n_s));
    ars_sync3 #(.INIT(1'b1)) u_rd (.clk(SYS_CLK), .srst(SRST), .din(HOST_RD_N), .dout(rd_n_s));
    ars_sync3 #(.INIT(1'b0)) u_strap (.clk(SYS_CLK), .srst(SRST), .din(SLAVE_STRAP), .dout(strap_s));

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            wr_n_d_r <= 1'b1;
        end else begin
            wr_n_d_r <= wr_n_s;
        end
    end

    // Strap is resampled on every idle cycle that carries no write strobe
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            is_slave_r <= 1'b0;
        end else if (state_r == S_IDLE && !wr_go) begin
            is_slave_r <= strap_s;
        end
    end

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    // A full divider is costly, but the LBA seek decision needs the track number
    function automatic logic [15:0] track_of(input logic [27:0] a, input logic lba);
        logic [27:0] q;
        q = a / TRACK_SIZE;
        track_of = lba ? q[15:0] : a[23:8];
    endfunction

    assign wr_go = wr_n_d_r & ~wr_n_s;
    assign lba_mode = dev_head_r[DH_LBA_BIT];
    assign addr = {dev_head_r[3:0], cyl_hi_r, cyl_lo_r, sect_r};
    assign busy = (state_r != S_IDLE) && (state_r != S_XFER);
    assign selected = (dev_head_r[DH_DRV_BIT] == is_slave_r);
    assign cmd_go = wr_go && (HOST_ADDR == ADR_COMMAND) && !busy && !DATA_REQ;
    // Low opcode bit is a don't-care for read
    assign start_read = cmd_go && selected && (HOST_WDATA[7:1] == OP_READ[7:1]);
    assign step = (state_r == S_XFER) && XFER_DONE && !err_r && (remain_r != 9'h001);
    assign target_cyl = track_of(addr, lba_mode);

    ars_addr_step u_step (.cur(addr), .lba_mode(lba_mode), .nxt(addr_nxt));

    // ------------------------------------------------------------
    // Task-file registers
    // ------------------------------------------------------------
    // Host writes during a command are dropped; the host must wait for idle
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            count_r <= RST_COUNT;
            sect_r <= RST_SECTOR;
            cyl_lo_r <= RST_ZERO;
            cyl_hi_r <= RST_ZERO;
            dev_head_r <= RST_ZERO;
        end else if (step) begin
            {dev_head_r[3:0], cyl_hi_r, cyl_lo_r, sect_r} <= addr_nxt;
            count_r <= 8'(remain_r - 9'h001);
        end else if (state_r == S_XFER && XFER_DONE && !err_r) begin
            count_r <= RST_ZERO;
        end else if (wr_go && !busy && !DATA_REQ) begin
            unique case (HOST_ADDR)
                // The read path has no use for the features byte, so it is dropped
                ADR_FEATURE: begin
                end
                ADR_COUNT: count_r <= HOST_WDATA;
                ADR_SECTOR: sect_r <= HOST_WDATA;
                ADR_CYL_LO: cyl_lo_r <= HOST_WDATA;
                ADR_CYL_HI: cyl_hi_r <= HOST_WDATA;
                ADR_DEV_HEAD: dev_head_r <= HOST_WDATA;
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Command sequencer
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            state_r <= S_IDLE;
            remain_r <= 9'h000;
            err_r <= 1'b0;
            fault_r <= DIAG_PASS;
            cur_cyl_r <= 16'h0000;
        end else begin
            unique case (state_r)
                S_IDLE: begin
                    if (start_read) begin
                        remain_r <= (count_r == RST_ZERO) ? MAX_COUNT : {1'b0, count_r};
                        err_r <= 1'b0;
                        fault_r <= RST_ZERO;
                        state_r <= S_CHECK;
                    end else if (cmd_go && HOST_WDATA == OP_DIAG) begin
                        // Executed whatever the drive-select bit says
                        err_r <= 1'b0;
                        fault_r <= DIAG_PASS;
                    end else if (cmd_go && selected) begin
                        err_r <= 1'b1;
                        fault_r <= 8'(1 << FLT_ABORT);
                    end
                end
                S_CHECK: begin
                    state_r <= (target_cyl != cur_cyl_r) ? S_SEEK : S_READ;
                end
                S_SEEK: begin
                    if (SEEK_DONE) begin
                        cur_cyl_r <= target_cyl;
                        state_r <= S_READ;
                    end
                end
                S_READ: begin
                    if (MEDIA_DONE) begin
                        if (MEDIA_ERR) begin
                            err_r <= 1'b1;
                            fault_r <= 8'(1 << FLT_UNC);
                        end
                        state_r <= S_XFER;
                    end
                end
                S_XFER: begin
                    if (XFER_DONE) begin
                        if (err_r || remain_r == 9'h001) begin
                            state_r <= S_IDLE;
                        end else begin
                            remain_r <= remain_r - 9'h001;
                            state_r <= S_CHECK;
                        end
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign SEEK_REQ = (state_r == S_SEEK);
    assign SEEK_CYL = target_cyl;
    assign MEDIA_REQ = (state_r == S_READ);
    assign MEDIA_ADDR = addr;
    assign MEDIA_LBA = lba_mode;
    assign DATA_REQ = (state_r == S_XFER);

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            HOST_RDATA <= RST_ZERO;
        end else if (!rd_n_s) begin
            unique case (HOST_ADDR)
                ADR_FEATURE: HOST_RDATA <= fault_r;
                ADR_COUNT: HOST_RDATA <= count_r;
                ADR_SECTOR: HOST_RDATA <= sect_r;
                ADR_CYL_LO: HOST_RDATA <= cyl_lo_r;
                ADR_CYL_HI: HOST_RDATA <= cyl_hi_r;
                ADR_DEV_HEAD: HOST_RDATA <= dev_head_r;
                ADR_COMMAND: begin
                    HOST_RDATA <= RST_ZERO;
                    HOST_RDATA[ST_BUSY] <= busy;
                    HOST_RDATA[ST_READY] <= 1'b1;
                    HOST_RDATA[ST_SEEKED] <= (state_r != S_SEEK);
                    HOST_RDATA[ST_DRQ] <= DATA_REQ;
                    HOST_RDATA[ST_ERR] <= err_r;
                end
                default: HOST_RDATA <= RST_ZERO;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SRST);

    a_both_opcodes: assert property (
        (cmd_go && selected && state_r == S_IDLE && (HOST_WDATA == OP_READ || HOST_WDATA == OP_READ_ALT))
        |=> state_r == S_CHECK)
        else $error("Read opcode not accepted");
    a_zero_count: assert property (
        (start_read && count_r == RST_ZERO && state_r == S_IDLE) |=> remain_r == MAX_COUNT)
        else $error("Zero count not taken as 256");
    a_lba_order: assert property (
        (step && MEDIA_LBA)
        |=> MEDIA_ADDR == $past(MEDIA_ADDR) + 28'h000_0001)
        else $error("LBA address not stepped by one");
    a_seek_miss: assert property (
        (state_r == S_CHECK && target_cyl != cur_cyl_r) |=> SEEK_REQ)
        else $error("No implied seek off track");
    a_drq_after_read: assert property (
        (MEDIA_REQ && MEDIA_DONE) |=> DATA_REQ && !busy)
        else $error("Data request not raised after sector");
    a_error_stops: assert property (
        (DATA_REQ && XFER_DONE && err_r) |=> state_r == S_IDLE && !MEDIA_REQ ##1 !MEDIA_REQ)
        else $error("Read continued after error");
    a_error_regs: assert property (
        (DATA_REQ && XFER_DONE && err_r) |=> $stable(MEDIA_ADDR) && $stable(count_r))
        else $error("Error registers changed");
    a_done_zero: assert property (
        (DATA_REQ && XFER_DONE && !err_r && remain_r == 9'h001) |=> count_r == RST_ZERO && $stable(MEDIA_ADDR))
        else $error("Count not zero at completion");
    a_step_count: assert property (
        step |=> count_r == 8'($past(remain_r) - 9'h001) && state_r == S_CHECK)
        else $error("Count not stepped");
    a_diag_any: assert property (
        (cmd_go && HOST_WDATA == OP_DIAG && state_r == S_IDLE) |=> fault_r == DIAG_PASS && !err_r)
        else $error("Diagnostic not executed");
    a_drive_select: assert property (
        (cmd_go && !selected && HOST_WDATA != OP_DIAG && state_r == S_IDLE)
        |=> state_r == S_IDLE && $stable(err_r) && $stable(fault_r))
        else $error("Command for the other drive acted on");
    a_abort_other: assert property (
        (cmd_go && selected && state_r == S_IDLE && HOST_WDATA[7:1] != OP_READ[7:1] && HOST_WDATA != OP_DIAG)
        |=> err_r && fault_r == 8'(1 << FLT_ABORT))
        else $error("Unsupported command not aborted");
    a_chs_cylinder: assert property (
        (state_r == S_CHECK && !MEDIA_LBA)
        |-> SEEK_CYL == {cyl_hi_r, cyl_lo_r})
        else $error("CHS cylinder taken from wrong registers");
    a_lba_cylinder: assert property (
        (state_r == S_CHECK && MEDIA_LBA)
        |-> SEEK_CYL == 16'(MEDIA_ADDR / TRACK_SIZE))
        else $error("LBA track not derived from full address");
    a_chs_step: assert property (
        (step && !MEDIA_LBA && sect_r < SECT_PER_TRACK)
        |=> sect_r == $past(sect_r) + 8'h01 && $stable(dev_head_r))
        else $error("CHS sector not stepped within track");
    a_seek_hit: assert property (
        (state_r == S_CHECK && target_cyl == cur_cyl_r)
        |=> MEDIA_REQ && !SEEK_REQ)
        else $error("Needless seek on track");
    a_error_drq: assert property (
        (MEDIA_REQ && MEDIA_DONE && MEDIA_ERR)
        |=> DATA_REQ && err_r)
        else $error("No data request for failed sector");
    a_error_count: assert property (
        (MEDIA_REQ && MEDIA_DONE && MEDIA_ERR)
        |=> count_r == 8'(remain_r))
        else $error("Count not left at remaining sectors");
    a_error_addr: assert property (
        (MEDIA_REQ && MEDIA_DONE && MEDIA_ERR)
        |=> $stable(MEDIA_ADDR) && fault_r[FLT_UNC])
        else $error("Failing sector address lost");
    a_busy_locks: assert property (
        busy
        |=> $stable(MEDIA_ADDR) && $stable(count_r))
        else $error("Parameters changed while busy");
    a_status_drq: assert property (
        (DATA_REQ && !rd_n_s && HOST_ADDR == ADR_COMMAND)
        |=> HOST_RDATA[ST_DRQ])
        else $error("Status lacks data request");
    a_status_busy: assert property (
        (busy && !rd_n_s && HOST_ADDR == ADR_COMMAND)
        |=> HOST_RDATA[ST_BUSY])
        else $error("Status lacks busy");

    // ------------------------------------------------------------
    // Cover points
    // ------------------------------------------------------------
    c_single_read: cover property (start_read ##[1:40] (DATA_REQ && XFER_DONE && remain_r == 9'h001));
    c_other_drive: cover property (cmd_go && !selected && HOST_WDATA == OP_DIAG);
    c_seek_read: cover property (SEEK_REQ && SEEK_DONE ##[1:10] DATA_REQ);
    c_media_err: cover property (MEDIA_REQ && MEDIA_DONE && MEDIA_ERR);
    c_multi: cover property (step ##[1:40] step);
endmodule

// File: verification/ars_media_model.sv
// Far-side responder for seek, media read and sector hand-off
`timescale 1ns/1ps
module ars_media_model (
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] dly,
    input wire logic seek_req,
    input wire logic media_req,
    input wire logic data_req,
    input wire logic [27:0] media_addr,
    input wire logic [27:0] err_addr,
    input wire logic err_en,
    input wire logic [15:0] seek_cyl,
    input wire logic media_lba,
    output logic seek_done,
    output logic media_done,
    output logic media_err,
    output logic xfer_done,
    output logic [31:0] n_seek,
    output logic [31:0] n_media,
    output logic [31:0] n_xfer,
    output logic [15:0] last_cyl,
    output logic last_lba
);
    logic [7:0] cnt;
    logic go;
    // Requests come one at a time, so one delay counter serves them all
    assign go = (cnt == dly) && !(seek_done || media_done || xfer_done);
    always_ff @(posedge clk) begin
        if (srst || seek_done || media_done || xfer_done || !(seek_req || media_req || data_req)) begin
            cnt <= 8'h00;
        end else if (cnt != dly) begin
            cnt <= cnt + 8'h01;
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            seek_done <= 1'b0;
            media_done <= 1'b0;
            xfer_done <= 1'b0;
        end else begin
            seek_done <= seek_req && go;
            media_done <= media_req && go;
            xfer_done <= data_req && go;
        end
    end
    // Outside a done pulse the error line toggles, so a stale level is never trusted
    always_ff @(posedge clk) begin
        if (srst) begin
            media_err <= 1'b0;
        end else if (media_req && go) begin
            media_err <= err_en && (media_addr === err_addr);
        end else begin
            media_err <= !media_err;
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            n_seek <= 32'h0000_0000;
            n_media <= 32'h0000_0000;
            n_xfer <= 32'h0000_0000;
        end else begin
            n_seek <= n_seek + 32'((seek_req && go) ? 1 : 0);
            n_media <= n_media + 32'((media_req && go) ? 1 : 0);
            n_xfer <= n_xfer + 32'((data_req && go) ? 1 : 0);
        end
    end
    // Remember what the last seek and media read asked for
    always_ff @(posedge clk) begin
        if (srst) begin
            last_cyl <= 16'h0000;
            last_lba <= 1'b0;
        end else begin
            if (seek_req && go) begin
                last_cyl <= seek_cyl;
            end
            if (media_req && go) begin
                last_lba <= media_lba;
            end
        end
    end
endmodule

// File: verification/tb_ata_read_sector_command.sv
// Self-checking bench for the read-sector command interpreter
`timescale 1ns/1ps
module tb_ata_read_sector_command;
    import ars_pkg::*;
    logic sys_clk, srst, host_wr_n, host_rd_n, slave_strap, err_en;
    logic [9:0] host_addr;
    logic [7:0] host_wdata, host_rdata, dly;
    logic seek_req, seek_done, media_req, media_done, media_err, data_req, xfer_done, media_lba, last_lba;
    logic [27:0] media_addr, err_addr;
    logic [15:0] seek_cyl, last_cyl;
    logic [31:0] n_seek, n_media, n_xfer, b_seek, b_media, b_xfer;
    int n_errors, checked;
    ars_read_sector_top u_dut (.SYS_CLK(sys_clk), .SRST(srst), .HOST_ADDR(host_addr),
        .HOST_WDATA(host_wdata), .HOST_WR_N(host_wr_n), .HOST_RD_N(host_rd_n), .HOST_RDATA(host_rdata),
        .SLAVE_STRAP(slave_strap), .SEEK_REQ(seek_req), .SEEK_CYL(seek_cyl), .SEEK_DONE(seek_done),
        .MEDIA_REQ(media_req), .MEDIA_ADDR(media_addr), .MEDIA_LBA(media_lba), .MEDIA_DONE(media_done),
        .MEDIA_ERR(media_err), .DATA_REQ(data_req), .XFER_DONE(xfer_done));
    ars_media_model u_model (.clk(sys_clk), .srst(srst), .dly(dly), .seek_req(seek_req),
        .media_req(media_req), .data_req(data_req), .media_addr(media_addr), .err_addr(err_addr),
        .err_en(err_en), .seek_done(seek_done), .media_done(media_done), .media_err(media_err),
        .xfer_done(xfer_done), .n_seek(n_seek), .n_media(n_media), .n_xfer(n_xfer),
        .seek_cyl(seek_cyl), .media_lba(media_lba), .last_cyl(last_cyl), .last_lba(last_lba));
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    // ------------------------------------------------------------
    // Host port access and comparison
    // ------------------------------------------------------------
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic checkn(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Strobes pass a three-flop filter, so both phases are held six cycles
    task automatic wr(input logic [9:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        host_addr <= a;
        host_wdata <= v;
        host_wr_n <= 1'b0;
        repeat (6) @(posedge sys_clk);
        host_wr_n <= 1'b1;
        repeat (6) @(posedge sys_clk);
    endtask
    task automatic rd(input logic [9:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        host_addr <= a;
        host_rd_n <= 1'b0;
        repeat (7) @(posedge sys_clk);
        @(negedge sys_clk);
        v = host_rdata;
        @(posedge sys_clk);
        host_rd_n <= 1'b1;
        repeat (5) @(posedge sys_clk);
    endtask
    task automatic rdchk(input logic [9:0] a, input logic [7:0] m, input logic [7:0] exp);
        logic [7:0] v;
        rd(a, v);
        check8(v & m, exp);
    endtask
    task automatic wait_idle();
        logic [7:0] s;
        for (int i = 0; i < 3000; i++) begin
            rd(ADR_COMMAND, s);
            if (s[ST_BUSY] === 1'b0 && s[ST_DRQ] === 1'b0) begin
                return;
            end
        end
        n_errors++;
        complete_run();
    endtask
    task automatic issue(input logic [7:0] dh, ch, cl, sn, sc, cmd);
        b_seek = n_seek;
        b_media = n_media;
        b_xfer = n_xfer;
        wr(ADR_FEATURE, 8'ha5);
        wr(ADR_COUNT, sc);
        wr(ADR_SECTOR, sn);
        wr(ADR_CYL_LO, cl);
        wr(ADR_CYL_HI, ch);
        wr(ADR_DEV_HEAD, dh);
        wr(ADR_COMMAND, cmd);
        wait_idle();
    endtask
    task automatic endchk(input logic [7:0] sc, sn, cl, ch, dh);
        rdchk(ADR_COUNT, 8'hff, sc);
        rdchk(ADR_SECTOR, 8'hff, sn);
        rdchk(ADR_CYL_LO, 8'hff, cl);
        rdchk(ADR_CYL_HI, 8'hff, ch);
        rdchk(ADR_DEV_HEAD, 8'h5f, dh);
    endtask
    task automatic counts(input int s, m, x);
        checkn(n_seek - b_seek, 32'(s));
        checkn(n_media - b_media, 32'(m));
        checkn(n_xfer - b_xfer, 32'(x));
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        srst = 1'b1;
        host_wr_n = 1'b1;
        host_rd_n = 1'b1;
        host_addr = ADR_FEATURE;
        host_wdata = 8'h00;
        slave_strap = 1'b0;
        dly = 8'h00;
        err_en = 1'b0;
        err_addr = 28'h000_0000;
        n_errors = 0;
        checked = 0;
        repeat (8) @(posedge sys_clk);
        srst <= 1'b0;
        repeat (6) @(posedge sys_clk);
        endchk(RST_COUNT, RST_SECTOR, RST_ZERO, RST_ZERO, RST_ZERO);
        rdchk(ADR_FEATURE, 8'hff, DIAG_PASS);
        rdchk(ADR_COMMAND, 8'hc9, 8'h40);
        rdchk(10'h01f0, 8'hff, 8'h00);
        $display("test 1 done: reset contents");
        dly <= 8'h03;
        issue(8'ha2, 8'h00, 8'h05, 8'h3e, 8'h03, OP_READ);
        endchk(8'h00, 8'h01, 8'h05, 8'h00, 8'h03);
        counts(1, 3, 3);
        checkn(32'({last_lba, last_cyl}), 32'h0000_0005);
        rdchk(ADR_COMMAND, 8'hc9, 8'h40);
        $display("test 2 done: slow chs read across a track");
        dly <= 8'h00;
        issue(8'he0, 8'h00, 8'h03, 8'hb0, 8'h02, OP_READ_ALT);
        endchk(8'h00, 8'hb1, 8'h03, 8'h00, 8'h40);
        counts(2, 2, 2);
        checkn(32'({last_lba, last_cyl}), 32'h0001_0001);
        $display("test 3 done: prompt lba read across a cylinder");
        err_addr <= 28'h000_0012;
        err_en <= 1'b1;
        dly <= 8'h02;
        issue(8'he0, 8'h00, 8'h00, 8'h10, 8'h04, OP_READ);
        endchk(8'h02, 8'h12, 8'h00, 8'h00, 8'h40);
        counts(1, 3, 3);
        checkn(32'({last_lba, last_cyl}), 32'h0001_0000);
        rdchk(ADR_COMMAND, 8'h01, 8'h01);
        rdchk(ADR_FEATURE, 8'h40, 8'h40);
        err_en <= 1'b0;
        $display("test 4 done: media error mid-read");
        dly <= 8'h00;
        issue(8'he0, 8'h00, 8'h00, 8'h00, 8'h00, OP_READ);
        endchk(8'h00, 8'hff, 8'h00, 8'h00, 8'h40);
        counts(0, 256, 256);
        rdchk(ADR_COMMAND, 8'hc9, 8'h40);
        $display("test 5 done: zero count reads the maximum");
        issue(8'hf0, 8'h00, 8'h00, 8'h00, 8'h01, OP_READ);
        counts(0, 0, 0);
        issue(8'he0, 8'h00, 8'h00, 8'h00, 8'h01, 8'hec);
        rdchk(ADR_COMMAND, 8'h01, 8'h01);
        rdchk(ADR_FEATURE, 8'h04, 8'h04);
        slave_strap <= 1'b1;
        repeat (8) @(posedge sys_clk);
        issue(8'ha0, 8'h00, 8'h00, 8'h00, 8'h00, OP_DIAG);
        rdchk(ADR_FEATURE, 8'hff, DIAG_PASS);
        $display("test 6 done: drive select, abort and diagnostic");
        complete_run();
    end
endmodule
